// File: hdl/boundary_run_test_engine.sv
// Purpose: Boundary register, control register and run-test operations.
// Assumes: TAP state and instruction decode come from the test controller.
// Notes:   Boundary logic runs on tck; clk only sees a synchronised flag.
`timescale 1ns/1ns
`default_nettype none
`include "boundary_test_cfg.svh"
// Function
// R1: Low control bits X00, X01, X10 pick toggle, 16-bit pattern, 16-bit signature.
// R2: Code 011 picks 8-bit signature plus pattern; 111 signature plus count.
// R3: Operations run only under run-test instruction in Run-Test/Idle.
// R4: Control cells 17 and 16 take no part in any operation.
// R5: Output-enable cell 16 still decides output drive during operations.
// R6: Control bits 10 to 3 mask inputs eight down to one.
// R7: A set mask bit removes its input from signatures; clear keeps it.
// R8: Toggle mode captures input pins each rising edge, passed to core.
// R9: Toggle mode inverts output stages rising, drives pins falling.
// R10: 16-bit pattern steps an LFSR rising, drives pins falling.
// R11: 16-bit pattern also feeds the core through input shadows.
// R12: An all-zero seed leaves pattern generators stuck.
// R13: Controller should scan a seed in before starting an operation.
// R14: 16-bit signature folds unmasked inputs each rising edge.
// R15: 16-bit signature holds output shadows and keeps driving them.
// R16: 8-bit modes compress unmasked inputs into input stages.
// R17: Combined pattern mode steps an 8-bit LFSR in output stages.
// R18: Combined count mode counts up in output stages.
// R19: Controller loads the control register before the run-test instruction.
// R20: Boundary read leaves the boundary register unchanged at capture.
// R21: Feedback taps are design parameters.
module boundary_run_test_engine
  import boundary_test_pkg::*;
#(
  parameter logic [15:0] TAPS16 = `TAPS16_DEF,
  parameter logic [7:0]  TAPS8  = `TAPS8_DEF
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       tck,
  input  wire logic       tdi,
  input  wire logic       tap_run_idle,
  input  wire logic       capture_dr,
  input  wire logic       shift_dr,
  input  wire logic       update_dr,
  input  wire logic       test_mode,
  input  wire logic       run_test_instruction,
  input  wire logic       boundary_read_normal,
  input  wire logic       boundary_select,
  input  wire logic       control_reg_scan_normal,
  input  wire logic [1:0] ctrl_pins,
  input  wire logic [7:0] data_pins,
  input  wire logic [7:0] core_q,
  output logic      [7:0] core_d,
  output logic      [7:0] q_out,
  output logic            q_oe,
  output logic            bsr_tdo,
  output logic            ctrl_tdo,
  output logic            run_active_tck,
  output logic            test_active
);
  import boundary_test_pkg::*;

  logic              rst_meta_reg;
  logic              trst_n_reg;
  logic [`BSR_W-1:0]  bsr_reg;
  logic [`BSR_W-1:0]  bsr_next;
  logic [`BSR_W-1:0]  shadow_reg;
  logic [`BSR_W-1:0]  shadow_next;
  logic [`CTRL_W-1:0] ctrl_sh_reg;
  logic [`CTRL_W-1:0] ctrl_sh_next;
  logic [`CTRL_W-1:0] boundary_test_control_reg;
  logic [`CTRL_W-1:0] boundary_test_control_next;
  logic              run_flag_reg;
  logic              act_meta_reg;
  logic              act_reg;

  boundary_step_if st ();

  boundary_step_unit #(
    .TAPS16 (TAPS16),
    .TAPS8  (TAPS8)
  ) u_step (
    .st (st)
  );

  // Reset crosses into the test clock domain through two flip-flops.
  always_ff @(posedge tck) begin
    rst_meta_reg <= reset_n;
    trst_n_reg   <= rst_meta_reg;
  end

  wire run_active = run_test_instruction & tap_run_idle;       // [R3]
  wire op_t op    = decode_op(boundary_test_control_reg[`CTRL_OP_HI:0]); // [R1] [R2]
  wire [7:0] in_stage  = bsr_reg[`BSR_IN_HI:`BSR_IN_LO];
  wire [7:0] out_stage = bsr_reg[`BSR_OUT_HI:`BSR_OUT_LO];
  wire bsr_shift   = boundary_select & shift_dr;
  wire bsr_capture = boundary_select & capture_dr & ~boundary_read_normal; // [R20]
  wire bsr_update  = boundary_select & update_dr;
  wire ctrl_shift  = control_reg_scan_normal & shift_dr;
  wire ctrl_update = control_reg_scan_normal & update_dr;       // [R19]

  assign st.op        = op;
  assign st.mask      = boundary_test_control_reg[`CTRL_MASK_HI:`CTRL_MASK_LO]; // [R6]
  assign st.pins      = data_pins;
  assign st.in_stage  = in_stage;
  assign st.out_stage = out_stage;

  // Run-test keeps the control cells and replaces the data cells.
  assign bsr_next =
    run_active  ? {bsr_reg[`BSR_CTRL_HI:`BSR_OE_BIT], st.in_next, st.out_next} : // [R3] [R4]
    bsr_shift   ? {tdi, bsr_reg[`BSR_W-1:1]} :
    bsr_capture ? {ctrl_pins, data_pins, core_q} :
    bsr_reg;                                                    // [R20]

  wire [7:0] in_shadow_next  = run_active ? in_stage :
                               (bsr_update ? in_stage : shadow_reg[`BSR_IN_HI:`BSR_IN_LO]);
  wire       out_load        = run_active ? st.out_upd : bsr_update; // [R15]
  wire [7:0] out_shadow_next = out_load ? out_stage : shadow_reg[`BSR_OUT_HI:`BSR_OUT_LO];
  wire [1:0] ctl_shadow_next = (bsr_update & ~run_active) ?
                               bsr_reg[`BSR_CTRL_HI:`BSR_OE_BIT] :
                               shadow_reg[`BSR_CTRL_HI:`BSR_OE_BIT];  // [R4]

  assign shadow_next = {ctl_shadow_next, in_shadow_next, out_shadow_next};

  assign ctrl_sh_next = ctrl_shift ? {tdi, ctrl_sh_reg[`CTRL_W-1:1]} : ctrl_sh_reg;
  assign boundary_test_control_next = ctrl_update ? ctrl_sh_reg : boundary_test_control_reg;

  // Shift stages and control register step on the rising edge.
  always_ff @(posedge tck) begin
    if (!trst_n_reg) begin
      bsr_reg                   <= '0;
      ctrl_sh_reg               <= '0;
      boundary_test_control_reg <= `CTRL_RESET;
      run_flag_reg              <= 1'b0;
    end else begin
      bsr_reg                   <= bsr_next;                   // [R8] [R10] [R14] [R16]
      ctrl_sh_reg               <= ctrl_sh_next;
      boundary_test_control_reg <= boundary_test_control_next;
      run_flag_reg              <= run_active;
    end
  end

  // Shadow latches load on the falling edge.
  always_ff @(negedge tck) begin
    if (!trst_n_reg) begin
      shadow_reg <= '0;
    end else begin
      shadow_reg <= shadow_next;                               // [R9] [R11] [R17] [R18]
    end
  end

  assign core_d  = test_mode ? shadow_reg[`BSR_IN_HI:`BSR_IN_LO] : data_pins;
  assign q_out   = test_mode ? shadow_reg[`BSR_OUT_HI:`BSR_OUT_LO] : core_q;
  assign q_oe    = test_mode ? ~shadow_reg[`BSR_OE_BIT] : ~ctrl_pins[0]; // [R5]
  assign bsr_tdo        = bsr_reg[0];
  assign ctrl_tdo       = ctrl_sh_reg[0];
  assign run_active_tck = run_flag_reg;

  // The running flag crosses to clk through two flip-flops.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      act_meta_reg <= 1'b0;
      act_reg      <= 1'b0;
    end else begin
      act_meta_reg <= run_flag_reg;
      act_reg      <= act_meta_reg;
    end
  end

  assign test_active = act_reg;

  default clocking cb @(posedge tck); endclocking
  default disable iff (!reset_n || !trst_n_reg);

  AST_DECODE: assert property (                               // [R1]
    boundary_test_control_reg[1:0] == 2'b00 |-> op == OP_TOGGLE)
    else $error("Code X00 did not select toggle mode.");

  AST_DECODE_COUNT: assert property (                         // [R2]
    boundary_test_control_reg[2:0] == 3'b111 |-> op == OP_SIGN8_COUNT)
    else $error("Code 111 did not select count mode.");

  AST_IDLE_HOLD: assert property (                            // [R3]
    !run_active && !boundary_select |=> $stable(bsr_reg))
    else $error("Boundary register changed outside run-test.");

  AST_CTRL_KEPT: assert property (                            // [R4]
    run_active |=> bsr_reg[`BSR_CTRL_HI:`BSR_OE_BIT] ==
                   $past(bsr_reg[`BSR_CTRL_HI:`BSR_OE_BIT]))
    else $error("Control cells changed during run-test.");

  AST_OE: assert property (                                   // [R5]
    test_mode |-> q_oe == ~shadow_reg[`BSR_OE_BIT])
    else $error("Output drive not decided by enable cell.");

  AST_MASK_ALL: assert property (                             // [R7]
    run_active && op == OP_SIGN8_COUNT && in_stage == 8'h00 &&
    boundary_test_control_reg[`CTRL_MASK_HI:`CTRL_MASK_LO] == 8'hff
    |=> in_stage == 8'h00)
    else $error("Masked inputs altered the signature.");

  AST_SAMPLE: assert property (                               // [R8]
    run_active && op == OP_TOGGLE |=> in_stage == $past(data_pins))
    else $error("Toggle mode did not sample input pins.");

  AST_TOGGLE: assert property (                               // [R9]
    run_active && op == OP_TOGGLE |=> out_stage == ~$past(out_stage))
    else $error("Toggle mode did not invert output stages.");

  AST_ZERO_STALL: assert property (                           // [R12]
    run_active && op == OP_PATTERN16 && in_stage == 8'h00 && out_stage == 8'h00
    |=> in_stage == 8'h00 && out_stage == 8'h00)
    else $error("Zero seed produced a new pattern.");

  AST_COUNT: assert property (                                // [R18]
    run_active && op == OP_SIGN8_COUNT |=> out_stage == 8'($past(out_stage) + 8'h01))
    else $error("Count mode did not increment.");

  AST_READ_HOLD: assert property (                            // [R20]
    boundary_select && capture_dr && boundary_read_normal && !run_active
    |=> $stable(bsr_reg))
    else $error("Boundary read changed the register at capture.");

  AST_PATTERN_STEP: assert property (                         // [R10]
    run_active && op == OP_PATTERN16 |=>
    bsr_reg[15:0] == {$past(bsr_reg[14:0]), ^($past(bsr_reg[15:0]) & TAPS16)})
    else $error("Pattern mode did not step the 16-bit sequence.");

  AST_LFSR8: assert property (                                // [R17]
    run_active && op == OP_SIGN8_PATTERN |=>
    out_stage == {$past(out_stage[6:0]), ^($past(out_stage) & TAPS8)})
    else $error("Combined pattern mode did not step the 8-bit sequence.");

  AST_IN_SHADOW: assert property (                            // [R11]
    run_active |=> shadow_reg[`BSR_IN_HI:`BSR_IN_LO] == in_stage)
    else $error("Input shadows did not follow the input stages.");

  AST_OUT_SHADOW: assert property (                           // [R9]
    run_active && op != OP_SIGN16 |=> shadow_reg[`BSR_OUT_HI:`BSR_OUT_LO] == out_stage)
    else $error("Output shadows did not follow the output stages.");

  AST_OUT_HOLD: assert property (                             // [R15]
    run_active && op == OP_SIGN16 |=> $stable(shadow_reg[`BSR_OUT_HI:`BSR_OUT_LO]))
    else $error("Output shadows moved during 16-bit signature.");

  COV_TOGGLE: cover property (run_active && op == OP_TOGGLE ##1 run_active);
  COV_PATTERN16: cover property (run_active && op == OP_PATTERN16 ##1 run_active);
  COV_SIGN16: cover property (run_active && op == OP_SIGN16 ##1 run_active);
  COV_COUNT: cover property (run_active && op == OP_SIGN8_COUNT ##1 run_active);
  COV_PATTERN8: cover property (run_active && op == OP_SIGN8_PATTERN ##1 run_active);
endmodule : boundary_run_test_engine
`default_nettype wire

// File: hdl/boundary_step_unit.sv
// Purpose: Next value of the boundary shift stages per test operation.
// Assumes: Stage values are taken from the rising-edge register.
// Notes:   Feedback taps are parameters.
`timescale 1ns/1ns
`default_nettype none
`include "boundary_test_cfg.svh"
module boundary_step_unit #(
  parameter logic [15:0] TAPS16 = `TAPS16_DEF,
  parameter logic [7:0]  TAPS8  = `TAPS8_DEF
) (
  boundary_step_if.step st
);
  import boundary_test_pkg::*;

  wire [7:0]  data_kept = st.pins & ~st.mask;                 // [R7]
  wire [15:0] reg16     = {st.in_stage, st.out_stage};
  wire [15:0] lfsr16    = {reg16[14:0], ^(reg16 & TAPS16)};   // [R21] [R12]
  wire [15:0] sign16    = lfsr16 ^ {data_kept, 8'h00};       // [R14]
  wire [7:0]  lfsr8_in  = {st.in_stage[6:0], ^(st.in_stage & TAPS8)};
  wire [7:0]  lfsr8_out = {st.out_stage[6:0], ^(st.out_stage & TAPS8)}; // [R12]
  wire [7:0]  sign8     = lfsr8_in ^ data_kept;               // [R16]
  wire [7:0]  count8    = st.out_stage + 8'h01;               // [R18]

  always_comb begin
    st.in_next  = st.in_stage;
    st.out_next = st.out_stage;
    st.out_upd  = 1'b1;
    unique case (st.op)
      OP_TOGGLE: begin
        st.in_next  = st.pins;                               // [R8]
        st.out_next = ~st.out_stage;                         // [R9]
      end
      OP_PATTERN16: begin
        st.in_next  = lfsr16[15:8];                          // [R10] [R11]
        st.out_next = lfsr16[7:0];
      end
      OP_SIGN16: begin
        st.in_next  = sign16[15:8];                          // [R14]
        st.out_next = sign16[7:0];
        st.out_upd  = 1'b0;                                  // [R15]
      end
      OP_SIGN8_PATTERN: begin
        st.in_next  = sign8;
        st.out_next = lfsr8_out;                             // [R17]
      end
      OP_SIGN8_COUNT: begin
        st.in_next  = sign8;
        st.out_next = count8;                                // [R18]
      end
      default: begin
        st.in_next  = st.in_stage;
        st.out_next = st.out_stage;
      end
    endcase
  end
endmodule : boundary_step_unit
`default_nettype wire

// File: shared/boundary_step_if.sv
// Purpose: Carries boundary stage state to the step unit and back.
// Assumes: Purely combinational traffic inside the test clock domain.
// Notes:   None.
`timescale 1ns/1ns
`default_nettype none
interface boundary_step_if;
  import boundary_test_pkg::*;
  op_t        op;
  logic [7:0] mask;
  logic [7:0] pins;
  logic [7:0] in_stage;
  logic [7:0] out_stage;
  logic [7:0] in_next;
  logic [7:0] out_next;
  logic       out_upd;
  modport engine (output op, mask, pins, in_stage, out_stage,
                  input in_next, out_next, out_upd);
  modport step (input op, mask, pins, in_stage, out_stage,
                output in_next, out_next, out_upd);
endinterface : boundary_step_if
`default_nettype wire

// File: shared/boundary_test_cfg.svh
// Purpose: Numeric constants of the boundary run-test engine.
// Assumes: Included by package and design files by bare name.
// Notes:   Definitions only.
`ifndef BOUNDARY_TEST_CFG_SVH
`define BOUNDARY_TEST_CFG_SVH
`define BSR_W         18
`define BSR_CTRL_HI   17
`define BSR_OE_BIT    16
`define BSR_IN_HI     15
`define BSR_IN_LO     8
`define BSR_OUT_HI    7
`define BSR_OUT_LO    0
`define CTRL_W        11
`define CTRL_OP_HI    2
`define CTRL_MASK_HI  10
`define CTRL_MASK_LO  3
`define CTRL_RESET    11'h000
`define TAPS16_DEF    16'hb400
`define TAPS8_DEF     8'hb8
`endif

// File: shared/boundary_test_pkg.sv
// Purpose: Types of the boundary run-test engine.
// Assumes: Constants come from boundary_test_cfg.svh.
// Notes:   Holds the operation codes shared by both modules and the decode used by the engine.
`include "boundary_test_cfg.svh"
package boundary_test_pkg;
  typedef enum logic [2:0] {
    OP_TOGGLE        = 3'b000,
    OP_PATTERN16     = 3'b001,
    OP_SIGN16        = 3'b010,
    OP_SIGN8_PATTERN = 3'b011,
    OP_SIGN8_COUNT   = 3'b111
  } op_t;

  // Maps the three low control bits onto the selected operation.
  function automatic op_t decode_op(input logic [2:0] code);
    unique case (code[1:0])
      2'b00: decode_op = OP_TOGGLE;
      2'b01: decode_op = OP_PATTERN16;
      2'b10: decode_op = OP_SIGN16;
      2'b11: decode_op = code[2] ? OP_SIGN8_COUNT : OP_SIGN8_PATTERN;
    endcase
  endfunction : decode_op
endpackage : boundary_test_pkg

// File: sim/boundary_run_test_engine_tb.sv
// Purpose: Self-checking bench of the boundary run-test engine.
// Assumes: Default feedback taps; the controller model owns the test clock.
// Notes:   Expected values come from the operation rules and the tap constants.
`timescale 1ns/1ns
`default_nettype none
`include "boundary_test_cfg.svh"
module boundary_run_test_engine_tb;
  import boundary_test_pkg::*;
  logic       clk;
  logic       reset_n;
  logic [1:0] ctrl_pins;
  logic [7:0] data_pins;
  logic [7:0] core_q;
  wire logic [7:0] core_d;
  wire logic [7:0] q_out;
  wire logic  q_oe, bsr_tdo, tck, tdi, run_idle, cap, sh, upd, tmode, rti, brn, bsel, crs;
  wire logic  ctrl_tdo, run_active_tck, test_active;
  int         fails;
  int         samples_checked;

  tap_ctrl_model tap (.tck(tck), .tdi(tdi), .tap_run_idle(run_idle), .capture_dr(cap),
    .shift_dr(sh), .update_dr(upd), .test_mode(tmode), .run_test_instruction(rti),
    .boundary_read_normal(brn), .boundary_select(bsel), .control_reg_scan_normal(crs),
    .bsr_tdo(bsr_tdo));

  boundary_run_test_engine dut (.clk(clk), .reset_n(reset_n), .tck(tck), .tdi(tdi),
    .tap_run_idle(run_idle), .capture_dr(cap), .shift_dr(sh), .update_dr(upd),
    .test_mode(tmode), .run_test_instruction(rti), .boundary_read_normal(brn),
    .boundary_select(bsel), .control_reg_scan_normal(crs), .ctrl_pins(ctrl_pins),
    .data_pins(data_pins), .core_q(core_q), .core_d(core_d), .q_out(q_out), .q_oe(q_oe),
    .bsr_tdo(bsr_tdo), .ctrl_tdo(ctrl_tdo), .run_active_tck(run_active_tck),
    .test_active(test_active));

  always #4 clk = ~clk;

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic seed(input logic [17:0] v);
    logic [17:0] o;
    tap.scan(v, o);
  endtask : seed

  task automatic t_toggle;
    logic [17:0] o;
    tap.load_ctrl(11'h004);
    seed({2'b00, 8'h00, 8'h5a});
    data_pins = 8'hc3;
    tap.run(1);
    chk({run_active_tck, q_oe, core_d, q_out}, {2'b11, 8'hc3, 8'ha5});
    data_pins = 8'h3c;
    tap.tick(1);
    chk({run_active_tck, core_d, q_out}, {1'b0, 8'hc3, 8'ha5});
    tap.run(1);
    chk({core_d, q_out}, {8'h3c, 8'h5a});
    seed({2'b01, 8'h00, 8'h0f});
    tap.run(1);
    chk({q_oe, q_out}, {1'b0, 8'hf0});
    tap.scan('0, o);
    chk(o[17:16], 2'b01);
  endtask : t_toggle

  task automatic t_pattern;
    logic [15:0] r;
    tap.load_ctrl(11'h001);
    seed({2'b00, 16'h1234});
    r = 16'h1234;
    for (int i = 0; i < 3; i++) begin
      tap.run(1);
      r = {r[14:0], ^(r & `TAPS16_DEF)};
      chk({core_d, q_out}, r);
      tap.tick(1);
    end
    seed('0);
    tap.run(3);
    chk({core_d, q_out}, 16'h0000);
    chk(test_active, 1'b1);
  endtask : t_pattern

  task automatic t_combined;
    logic [7:0] p;
    tap.load_ctrl(11'h003);
    chk(test_active, 1'b0);
    seed({2'b00, 8'h00, 8'h81});
    p = 8'h81;
    tap.run(1);
    p = {p[6:0], ^(p & `TAPS8_DEF)};
    chk(q_out, p);
    seed('0);
    tap.run(3);
    chk(q_out, 8'h00);
    tap.load_ctrl(11'h007);
    seed({2'b00, 8'h00, 8'hfe});
    tap.run(1);
    chk(q_out, 8'hff);
    tap.tick(1);
    tap.run(1);
    chk(q_out, 8'h00);
    tap.load_ctrl(11'h7ff);
    seed({2'b00, 8'h00, 8'h10});
    data_pins = 8'hff;
    tap.run(2);
    chk({core_d, q_out}, {8'h00, 8'h12});
  endtask : t_combined

  task automatic sig(input logic [10:0] c, input logic [7:0] d, output logic [7:0] s);
    tap.load_ctrl(c);
    chk(ctrl_tdo, c[0]);
    seed({2'b00, 8'h5c, 8'h69});
    data_pins = d;
    tap.run(1);
    s = core_d;
  endtask : sig

  task automatic t_mask;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [17:0] o;
    sig(11'h402, 8'h80, a);
    sig(11'h402, 8'h00, b);
    chk(a, b);
    chk(q_out, 8'h69);
    sig(11'h402, 8'h01, a);
    chk({17'h0, a !== b}, 18'h1);
    sig(11'h00f, 8'h01, a);
    sig(11'h00f, 8'h00, b);
    chk(a, b);
    sig(11'h403, 8'h01, a);
    sig(11'h403, 8'h00, b);
    chk({17'h0, a !== b}, 18'h1);
    tap.read_hold();
    tap.tick(1);
    tap.scan('0, o);
    chk(o[15:8], b);
  endtask : t_mask

  task automatic t_normal;
    logic [17:0] o;
    tap.set_mode(1'b0);
    ctrl_pins = 2'b01;
    core_q    = 8'h69;
    data_pins = 8'h5a;
    tap.capture_cells();
    chk({q_oe, core_d, q_out}, {1'b0, 8'h5a, 8'h69});
    tap.tick(1);
    tap.scan('0, o);
    chk(o, {2'b01, 8'h5a, 8'h69});
    tap.set_mode(1'b1);
    tap.tick(1);
    chk({q_oe, q_out}, {1'b1, 8'h00});
  endtask : t_normal

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    ctrl_pins = 2'b10;
    data_pins = 8'h00;
    core_q = 8'h96;
    fails = 0;
    samples_checked = 0;
    fork
      begin
        repeat (5) @(posedge clk);
        #1 reset_n = 1'b1;
      end
      tap.tick(6);
    join
    tap.tick(4);
    t_toggle();
    t_pattern();
    t_combined();
    t_mask();
    t_normal();
    stop_test();
  end

  initial begin
    #200000;
    fails++;
    stop_test();
  end
endmodule : boundary_run_test_engine_tb
`default_nettype wire

// File: sim/tap_ctrl_model.sv
// Purpose: Test controller model that drives the TAP state lines of the engine.
// Assumes: The test clock only runs inside the tasks, and stands still between them.
// Notes:   Signals change 4 ns after a falling edge and are held across the rising edge.
`timescale 1ns/1ns
`default_nettype none
module tap_ctrl_model (
  output logic      tck,
  output logic      tdi,
  output logic      tap_run_idle,
  output logic      capture_dr,
  output logic      shift_dr,
  output logic      update_dr,
  output logic      test_mode,
  output logic      run_test_instruction,
  output logic      boundary_read_normal,
  output logic      boundary_select,
  output logic      control_reg_scan_normal,
  input  wire logic bsr_tdo
);
  initial begin
    {tck, tdi, tap_run_idle, capture_dr, shift_dr, update_dr} = '0;
    {run_test_instruction, boundary_read_normal, boundary_select} = '0;
    control_reg_scan_normal = 1'b0;
    test_mode = 1'b1;
  end

  // Runs whole test-clock periods of 15 ns.
  task automatic tick(input int n);
    repeat (n) begin
      #4 tck = 1'b1;
      #7 tck = 1'b0;
      #4;
    end
  endtask : tick

  // Loads the control register before any run is started.
  task automatic load_ctrl(input logic [10:0] v);
    control_reg_scan_normal = 1'b1;
    shift_dr = 1'b1;
    for (int i = 0; i < 11; i++) begin
      tdi = v[i];
      tick(1);
    end
    tdi = ~tdi;
    shift_dr = 1'b0;
    update_dr = 1'b1;
    tick(1);
    update_dr = 1'b0;
    control_reg_scan_normal = 1'b0;
  endtask : load_ctrl

  // Shifts a seed in, collects the old content, then updates the shadows.
  task automatic scan(input logic [17:0] v, output logic [17:0] o);
    boundary_select = 1'b1;
    shift_dr = 1'b1;
    for (int i = 0; i < 18; i++) begin
      o[i] = bsr_tdo;
      tdi = v[i];
      tick(1);
    end
    tdi = ~tdi;
    shift_dr = 1'b0;
    update_dr = 1'b1;
    tick(1);
    update_dr = 1'b0;
    boundary_select = 1'b0;
  endtask : scan

  // Captures under the boundary read instruction.
  task automatic read_hold;
    boundary_read_normal = 1'b1;
    boundary_select = 1'b1;
    capture_dr = 1'b1;
    tick(1);
    capture_dr = 1'b0;
    boundary_select = 1'b0;
    boundary_read_normal = 1'b0;
  endtask : read_hold

  // Switches between test mode and normal mode.
  task automatic set_mode(input logic m);
    test_mode = m;
  endtask : set_mode

  // Captures pins and core outputs under a scanning instruction.
  task automatic capture_cells;
    boundary_select = 1'b1;
    capture_dr = 1'b1;
    tick(1);
    capture_dr = 1'b0;
    boundary_select = 1'b0;
  endtask : capture_cells

  // Stays in Run-Test/Idle under the run-test instruction.
  task automatic run(input int n);
    run_test_instruction = 1'b1;
    tap_run_idle = 1'b1;
    tick(n);
    tap_run_idle = 1'b0;
    run_test_instruction = 1'b0;
  endtask : run
endmodule : tap_ctrl_model
`default_nettype wire
